/* File: design/host_port_pkg.sv */
// Constants, field positions and types for the host I/O bus port.
// *************************************************************
// Overview of operation
// RULE_01 - Port answers data and control commands only when the select lines hold its code.
// RULE_02 - Interrupt cycles carry channel on select 4-6, physical number on 0-3.
// RULE_03 - Function lines 000..101 decode to the six bus commands.
// RULE_04 - A command starts only when the host raises the command strobe.
// RULE_05 - Accept rises while a command executes, never for interrupt-served.
// RULE_06 - Done rises when the command is finished, never for interrupt-served.
// RULE_07 - Interrupt request drives the request line chosen by the written level.
// RULE_08 - Data disable from the host turns all data drivers off at once.
// RULE_09 - Port drives the data lines only for read commands addressed to it.
// RULE_10 - All port logic runs on the clock supplied by the host.
// RULE_11 - Host bus and microengine take turns on the buffer; the bus wins.
// RULE_12 - Diagnostic data-out and data-in act only while the run bit is clear.
// RULE_13 - Stopped data-out with bit 00 set loads D01-D13 into the microstore address.
// RULE_14 - Stopped data-out with bit 00 clear writes 28 low bits into one store half.
// RULE_15 - Stopped data-in with select bit 21 clear reads the addressed store half.
// RULE_16 - Stopped data-in with select bit 21 set reads the latched next address on D01-D12.
// RULE_17 - Stopped data-out with loopback bit 19 set loads BUS_DATA_LINES into the buffer.
// RULE_18 - Stopped data-in with loopback bit 19 set returns the buffer.
// RULE_19 - Control-out writes every host-writable control bit; others keep their value.
// RULE_20 - Control-in returns every host-readable control bit.
// RULE_21 - While running control-out and control-in are still accepted, unchanged.
// RULE_22 - Host data-out or data-in while running is ignored and gets no done.
// RULE_23 - Data transfers answering an engine examine or deposit request stay legal.
// RULE_24 - Setting the run bit clears the store control and starts at the address register.
// RULE_25 - Control bits 33-35 give interrupt level one to seven.
// RULE_26 - Host reset stops the engine, idles handshakes and turns drivers off.
// RULE_27 - Loopback bit wins over address, store word and next address access.
// *************************************************************
package host_port_pkg;

   // Widths
   localparam int DATA_W = 36;
   localparam int SEL_W = 7;
   localparam int FN_W = 3;
   localparam int IRQ_W = 8;
   localparam int CS_ADDR_W = 13;
   localparam int CS_DEPTH = 8192;
   localparam int HALF_W = 28;
   localparam int WORD_W = 56;
   localparam int LAR_W = 12;
   localparam int PIA_W = 3;
   localparam int CHAN_W = 3;
   localparam int PHYS_W = 4;

   // Function codes
   localparam logic [2:0] FN_CONTROL_OUT = 3'h0;
   localparam logic [2:0] FN_CONTROL_IN = 3'h1;
   localparam logic [2:0] FN_DATA_OUT = 3'h2;
   localparam logic [2:0] FN_DATA_IN = 3'h3;
   localparam logic [2:0] FN_INTR_SERVED = 3'h4;
   localparam logic [2:0] FN_INTR_VECTOR = 3'h5;

   // Bit positions on the bus, bit 00 is the leftmost
   localparam int D_LOAD_ADDR = 0;
   localparam int D_ADDR_FIRST = 1;
   localparam int D_ADDR_LAST = 13;
   localparam int D_LAR_LAST = 12;
   localparam int D_HALF_FIRST = 8;
   localparam int D_LAST = 35;
   localparam int SEL_CHAN_FIRST = 4;
   localparam int SEL_CHAN_LAST = 6;
   localparam int SEL_PHYS_FIRST = 0;
   localparam int SEL_PHYS_LAST = 3;

   // Control register bits
   localparam int CSR_HALF_SEL = 11;
   localparam int CSR_ID_FIRST = 15;
   localparam int CSR_ID_LAST = 17;
   localparam int CSR_CLEAR_PORT = 18;
   localparam int CSR_LOOPBACK = 19;
   localparam int CSR_SEL_NEXT = 21;
   localparam int CSR_PAR_ERR = 24;
   localparam int CSR_RUN = 32;
   localparam int CSR_PIA_FIRST = 33;
   localparam int CSR_PIA_LAST = 35;
   localparam logic [0:35] CSR_RESET = 36'h0;
   localparam logic [0:35] CSR_WR_MASK = 36'h0_0103_F93F;
   localparam logic [0:35] CSR_RD_MASK = 36'h0_01FF_FFBF;

   // Function field of the engine's request word
   localparam int IOP_FN_FIRST = 3;
   localparam int IOP_FN_LAST = 5;
   localparam logic [2:0] IOP_EXAMINE = 3'h4;
   localparam logic [2:0] IOP_DEPOSIT = 3'h5;
   localparam logic [2:0] IOP_EXAMINE_INC = 3'h7;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_EXEC = 4'h2,
      ST_DONE = 4'h4,
      ST_IGNORE = 4'h8
   } state_type;

endpackage

/* File: design/host_port.sv */
// Slave control logic joining the port to the host parallel I/O bus.
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module host_port #(
   parameter logic [6:0] DEVICE_CODE = 7'h2A,  // Arbitrary value
   parameter logic [3:0] PHYS_NUMBER = 4'h5,   // Arbitrary value
   parameter logic [2:0] PORT_ID = 3'h6        // Arbitrary value
) (
   // Clock and reset from the host execution unit
   input wire logic mclk_in,
   input wire logic arst_n_in,
   // Host bus command group
   input wire logic [0:host_port_pkg::SEL_W-1] device_select_lines_in,
   input wire logic [0:host_port_pkg::FN_W-1] function_code_lines_in,
   input wire logic command_strobe_in,
   input wire logic data_disable_in,
   output logic command_accept_out,
   output logic transfer_done_out,
   // Host bus data lines
   input wire logic [0:host_port_pkg::DATA_W-1] bus_data_lines_in,
   output logic [0:host_port_pkg::DATA_W-1] bus_data_lines_out,
   output logic bus_data_lines_oe_out,
   // Interrupt requests, index is the level
   output logic [0:host_port_pkg::IRQ_W-1] interrupt_request_lines_out,
   // Microengine control
   output logic engine_run_out,
   output logic engine_clear_out,
   output logic [host_port_pkg::CS_ADDR_W-1:0] engine_start_addr_out,
   output logic [0:host_port_pkg::DATA_W-1] control_status_out,
   input wire logic engine_halt_in,
   input wire logic engine_lar_load_in,
   input wire logic [host_port_pkg::LAR_W-1:0] engine_next_addr_in,
   // Microengine store fetch
   input wire logic [host_port_pkg::CS_ADDR_W-1:0] engine_fetch_addr_in,
   output logic [host_port_pkg::WORD_W-1:0] engine_fetch_word_out,
   // Microengine buffer access
   input wire logic engine_buf_load_in,
   input wire logic engine_intr_in,
   input wire logic [0:host_port_pkg::DATA_W-1] engine_buf_data_in,
   output logic engine_buf_ready_out,
   output logic [0:host_port_pkg::DATA_W-1] engine_buf_data_out,
   output logic engine_data_event_out
);
   import host_port_pkg::*;

   // *************************************************************
   // State
   // *************************************************************
   typedef struct packed {
      state_type state;
      logic [2:0] cmd;
      logic [0:DATA_W-1] control_status_reg;
      logic [CS_ADDR_W-1:0] microstore_addr_reg;
      logic [LAR_W-1:0] latched_next_addr;
      logic [0:DATA_W-1] bus_buf;
      logic [0:DATA_W-1] rdata;
      logic drive;
      logic accept;
      logic done;
      logic intr_pending;
      logic transfer_done_allowed;
      logic clear_pulse;
      logic data_event;
      logic [0:IRQ_W-1] irq;
      logic [WORD_W-1:0] fetch_word;
   } port_state_type;

   localparam port_state_type STATE_RESET = '{
      state: ST_IDLE,
      cmd: FN_CONTROL_OUT,
      control_status_reg: CSR_RESET,
      microstore_addr_reg: '0,
      latched_next_addr: '0,
      bus_buf: '0,
      rdata: '0,
      drive: 1'h0,
      accept: 1'h0,
      done: 1'h0,
      intr_pending: 1'h0,
      transfer_done_allowed: 1'h0,
      clear_pulse: 1'h0,
      data_event: 1'h0,
      irq: '0,
      fetch_word: '0
   };

   port_state_type state_reg;
   port_state_type state_next;

   // Control store, two 28-bit halves per word
   logic [WORD_W-1:0] control_store [0:CS_DEPTH-1];
   logic cs_we;
   logic cs_half;
   logic [HALF_W-1:0] cs_wdata;

   // *************************************************************
   // Decode helpers
   // *************************************************************
   function automatic logic is_read(input logic [2:0] fn);
      return (fn == FN_CONTROL_IN) || (fn == FN_DATA_IN) || (fn == FN_INTR_VECTOR);
   endfunction

   function automatic logic [0:IRQ_W-1] level_line(input logic [2:0] level);
      logic [0:IRQ_W-1] lines;
      lines = '0;
      if (level != 3'h0) begin
         lines[level] = 1'h1;
      end
      return lines;
   endfunction

   logic dev_match;
   logic vec_match;
   logic running;
   logic [2:0] interrupt_level_assign;
   logic engine_buf_take;

   assign running = state_reg.control_status_reg[CSR_RUN];
   assign interrupt_level_assign = state_reg.control_status_reg[CSR_PIA_FIRST:CSR_PIA_LAST];  // [RULE_25]
   assign dev_match = (device_select_lines_in == DEVICE_CODE);  // [RULE_01]
   assign vec_match = (device_select_lines_in[SEL_CHAN_FIRST:SEL_CHAN_LAST] == interrupt_level_assign)
      && (device_select_lines_in[SEL_PHYS_FIRST:SEL_PHYS_LAST] == PHYS_NUMBER)
      && state_reg.intr_pending;  // [RULE_02]
   // The engine only touches the buffer while no host command is in flight
   assign engine_buf_take = (engine_buf_load_in || engine_intr_in)
      && (state_reg.state == ST_IDLE) && !command_strobe_in;  // [RULE_11]

   // *************************************************************
   // Next state
   // *************************************************************
   always_comb begin
      logic legal;
      logic [0:DATA_W-1] din;
      logic [0:DATA_W-1] rd_csr;
      legal = 1'h0;
      din = bus_data_lines_in;
      rd_csr = '0;
      state_next = state_reg;
      state_next.clear_pulse = 1'h0;
      state_next.data_event = 1'h0;
      cs_we = 1'h0;
      cs_half = state_reg.control_status_reg[CSR_HALF_SEL];
      cs_wdata = din[D_HALF_FIRST:D_LAST];
      state_next.fetch_word = control_store[engine_fetch_addr_in];

      if (engine_lar_load_in) begin
         state_next.latched_next_addr = engine_next_addr_in;
      end
      if (engine_halt_in) begin
         state_next.control_status_reg[CSR_RUN] = 1'h0;
      end
      if (engine_buf_take) begin
         state_next.bus_buf = engine_buf_data_in;
         if (engine_intr_in) begin
            state_next.intr_pending = 1'h1;
            // Examine and deposit requests open a window for host data transfers
            state_next.transfer_done_allowed =
               (engine_buf_data_in[IOP_FN_FIRST:IOP_FN_LAST] == IOP_EXAMINE)
               || (engine_buf_data_in[IOP_FN_FIRST:IOP_FN_LAST] == IOP_DEPOSIT)
               || (engine_buf_data_in[IOP_FN_FIRST:IOP_FN_LAST] == IOP_EXAMINE_INC);
         end
      end

      unique case (state_reg.state)
         ST_IDLE: begin
            if (command_strobe_in) begin  // [RULE_04]
               unique case (function_code_lines_in)  // [RULE_03]
                  FN_CONTROL_OUT, FN_CONTROL_IN: begin
                     legal = dev_match;  // [RULE_21]
                  end
                  FN_DATA_OUT, FN_DATA_IN: begin
                     // Host software transfers while running get no answer unless an examine or deposit window is open
                     legal = dev_match && (!running || state_reg.transfer_done_allowed);  // [RULE_22] [RULE_23]
                  end
                  FN_INTR_VECTOR: begin
                     legal = vec_match;
                  end
                  default: begin
                     legal = 1'h0;  // [RULE_05] [RULE_06]
                  end
               endcase
               state_next.cmd = function_code_lines_in;
               if (legal) begin
                  state_next.state = ST_EXEC;
                  state_next.accept = 1'h1;  // [RULE_05]
               end else begin
                  state_next.state = ST_IGNORE;
               end
            end
         end
         ST_EXEC: begin
            state_next.state = ST_DONE;
            state_next.done = 1'h1;  // [RULE_06]
            state_next.drive = is_read(state_reg.cmd);  // [RULE_09]
            unique case (state_reg.cmd)
               FN_CONTROL_OUT: begin
                  // Host-writable bits only; the rest hold  [RULE_19]
                  state_next.control_status_reg = (state_reg.control_status_reg & ~CSR_WR_MASK) | (din & CSR_WR_MASK);
                  if (engine_halt_in) begin
                     state_next.control_status_reg[CSR_RUN] = din[CSR_RUN];
                  end
                  if (din[CSR_PAR_ERR]) begin
                     state_next.control_status_reg[CSR_PAR_ERR] = 1'h0;
                  end
                  if (din[CSR_RUN] && !running) begin
                     state_next.clear_pulse = 1'h1;  // [RULE_24]
                  end
                  if (din[CSR_CLEAR_PORT]) begin
                     state_next = STATE_RESET;
                     state_next.state = ST_DONE;
                     state_next.accept = 1'h1;
                     state_next.done = 1'h1;
                  end
               end
               FN_CONTROL_IN: begin
                  rd_csr = state_reg.control_status_reg & CSR_RD_MASK;
                  rd_csr[CSR_ID_FIRST:CSR_ID_LAST] = PORT_ID;
                  state_next.rdata = rd_csr;  // [RULE_20]
               end
               FN_DATA_OUT: begin
                  if (running) begin
                     state_next.bus_buf = din;  // [RULE_23]
                     state_next.transfer_done_allowed = 1'h0;
                     state_next.data_event = 1'h1;
                  end else if (state_reg.control_status_reg[CSR_LOOPBACK]) begin
                     state_next.bus_buf = din;  // [RULE_17] [RULE_27]
                  end else if (din[D_LOAD_ADDR]) begin
                     state_next.microstore_addr_reg = din[D_ADDR_FIRST:D_ADDR_LAST];  // [RULE_13]
                  end else begin
                     cs_we = 1'h1;  // [RULE_14]
                  end
               end
               FN_DATA_IN: begin
                  state_next.rdata = '0;
                  if (running) begin
                     state_next.rdata = state_reg.bus_buf;  // [RULE_23]
                     state_next.transfer_done_allowed = 1'h0;
                     state_next.data_event = 1'h1;
                  end else if (state_reg.control_status_reg[CSR_LOOPBACK]) begin
                     state_next.rdata = state_reg.bus_buf;  // [RULE_18] [RULE_27]
                  end else if (state_reg.control_status_reg[CSR_SEL_NEXT]) begin
                     state_next.rdata[D_ADDR_FIRST:D_LAR_LAST] = state_reg.latched_next_addr;  // [RULE_16]
                  end else if (cs_half) begin
                     state_next.rdata[D_HALF_FIRST:D_LAST] =
                        control_store[state_reg.microstore_addr_reg][WORD_W-1:HALF_W];  // [RULE_15]
                  end else begin
                     state_next.rdata[D_HALF_FIRST:D_LAST] =
                        control_store[state_reg.microstore_addr_reg][HALF_W-1:0];  // [RULE_15]
                  end
               end
               default: begin
                  // Vector read hands over the request word and retires the request
                  state_next.rdata = state_reg.bus_buf;
                  state_next.intr_pending = 1'h0;
               end
            endcase
         end
         ST_DONE: begin
            if (!command_strobe_in) begin
               state_next.state = ST_IDLE;
               state_next.accept = 1'h0;
               state_next.done = 1'h0;
               state_next.drive = 1'h0;
            end
         end
         ST_IGNORE: begin
            if (!command_strobe_in) begin
               state_next.state = ST_IDLE;
            end
         end
      endcase

      // Request line follows the level held after this cycle
      state_next.irq = state_next.intr_pending
         ? level_line(state_next.control_status_reg[CSR_PIA_FIRST:CSR_PIA_LAST]) : '0;  // [RULE_07]
   end

   // *************************************************************
   // Registers, all on the host-supplied clock
   // *************************************************************
   always_ff @(posedge mclk_in or negedge arst_n_in) begin  // [RULE_10]
      if (!arst_n_in) begin
         state_reg <= STATE_RESET;  // [RULE_26]
      end else begin
         state_reg <= state_next;
      end
   end

   // Store has no reset; contents survive a port clear
   always_ff @(posedge mclk_in) begin
      if (cs_we) begin
         if (cs_half) begin
            control_store[state_reg.microstore_addr_reg][WORD_W-1:HALF_W] <= cs_wdata;  // [RULE_14]
         end else begin
            control_store[state_reg.microstore_addr_reg][HALF_W-1:0] <= cs_wdata;
         end
      end
   end

   // *************************************************************
   // Outputs
   // *************************************************************
   assign command_accept_out = state_reg.accept;
   assign transfer_done_out = state_reg.done;
   assign bus_data_lines_out = state_reg.rdata;
   // Disable acts at once so diagnostic data never meets our drivers
   assign bus_data_lines_oe_out = state_reg.drive && !data_disable_in;  // [RULE_08] [RULE_09]
   assign interrupt_request_lines_out = state_reg.irq;
   assign engine_run_out = running;  // [RULE_12]
   assign engine_clear_out = state_reg.clear_pulse;
   assign engine_start_addr_out = state_reg.microstore_addr_reg;  // [RULE_24]
   assign control_status_out = state_reg.control_status_reg;
   assign engine_fetch_word_out = state_reg.fetch_word;
   assign engine_buf_ready_out = (state_reg.state == ST_IDLE) && !command_strobe_in;
   assign engine_buf_data_out = state_reg.bus_buf;
   assign engine_data_event_out = state_reg.data_event;

endmodule

/* File: bench/host_port_chk.sv */
// Concurrent checks on the host bus port pins.
`timescale 1ns/1ps
module host_port_chk #(
   parameter logic [6:0] DEVICE_CODE = 7'h2A
) (
   // Clock, reset and host command group
   input wire logic mclk_in,
   input wire logic arst_n_in,
   input wire logic [0:host_port_pkg::SEL_W-1] device_select_lines_in,
   input wire logic [0:host_port_pkg::FN_W-1] function_code_lines_in,
   input wire logic command_strobe_in,
   input wire logic data_disable_in,
   // Port answers
   input wire logic command_accept_out,
   input wire logic transfer_done_out,
   input wire logic bus_data_lines_oe_out,
   input wire logic [0:host_port_pkg::IRQ_W-1] interrupt_request_lines_out,
   input wire logic engine_run_out,
   input wire logic engine_clear_out,
   input wire logic engine_data_event_out,
   input wire logic [0:host_port_pkg::DATA_W-1] control_status_out
);
   import host_port_pkg::*;
   // ****************
   // Properties
   // ****************
   logic sel_match;
   assign sel_match = device_select_lines_in == DEVICE_CODE;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!arst_n_in);
   reset_idle_a: assert property ($rose(arst_n_in) |-> !command_accept_out &&
      !transfer_done_out && !bus_data_lines_oe_out && !engine_run_out)
      else $error("outputs not idle after reset");
   ctl_accept_a: assert property ($rose(command_strobe_in) && sel_match &&
      function_code_lines_in[0:1] == 2'h0 |=> command_accept_out)
      else $error("control command not accepted");
   foreign_code_a: assert property ($rose(command_strobe_in) && !sel_match &&
      !function_code_lines_in[0] |=> !command_accept_out [*2])
      else $error("accepted a foreign device code");
   served_quiet_a: assert property (command_strobe_in && $past(command_strobe_in) &&
      function_code_lines_in == FN_INTR_SERVED && $stable(function_code_lines_in)
      |-> !command_accept_out && !transfer_done_out) else $error("answered served cycle");
   done_follows_a: assert property ($rose(command_accept_out) |=> transfer_done_out)
      else $error("done missing after accept");
   done_stands_a: assert property (transfer_done_out && command_strobe_in |=>
      transfer_done_out) else $error("done dropped under strobe");
   drive_off_a: assert property (data_disable_in |-> !bus_data_lines_oe_out)
      else $error("driving while disabled");
   read_drive_a: assert property ($rose(bus_data_lines_oe_out) && !$past(data_disable_in)
      |-> command_strobe_in && function_code_lines_in[2]) else $error("drive without read");
   irq_level_a: assert property (interrupt_request_lines_out != 8'h00 |->
      interrupt_request_lines_out == (8'h80 >> control_status_out[CSR_PIA_FIRST:CSR_PIA_LAST]))
      else $error("request on wrong level");
   run_clear_a: assert property ($rose(engine_run_out) |-> engine_clear_out ##1
      !engine_clear_out) else $error("no clear pulse on run");
   data_event_a: assert property (engine_data_event_out |-> transfer_done_out &&
      engine_run_out) else $error("data event outside running transfer");
   accept_seen_c: cover property ($rose(command_accept_out));
   irq_seen_c: cover property (interrupt_request_lines_out != 8'h00);
   run_seen_c: cover property ($rose(engine_run_out));
   drive_seen_c: cover property ($rose(bus_data_lines_oe_out));
endmodule
bind host_port host_port_chk #(.DEVICE_CODE(DEVICE_CODE)) chk (.*);

/* File: bench/host_bus_model.sv */
// Host execution unit model issuing commands on the port bus.
`timescale 1ns/1ps
module host_bus_model (
   // Clock and port answers
   input wire logic mclk_in,
   input wire logic transfer_done_in,
   input wire logic bus_oe_in,
   input wire logic [0:35] bus_wire_in,
   // Command lines towards the port
   output logic [0:6] device_select_lines_out,
   output logic [0:2] function_code_lines_out,
   output logic command_strobe_out,
   output logic data_disable_out,
   output logic [0:35] host_data_out
);
   // ****************
   // Command cycle
   // ****************
   initial begin
      device_select_lines_out = 7'h00;
      function_code_lines_out = 3'h0;
      command_strobe_out = 1'b0;
      data_disable_out = 1'b0;
      host_data_out = 36'h5_A5A5_A5A5;
   end
   // Released data lines show the inverse of the last value, never a stale copy
   task automatic cmd(input logic [0:6] sel, input logic [0:2] fn, input logic [0:35] wd,
         input logic dis, output logic ok, output logic [0:35] rd, output logic oe);
      ok = 1'b0;
      rd = 36'h0;
      oe = 1'b0;
      @(posedge mclk_in);
      device_select_lines_out <= sel;
      function_code_lines_out <= fn;
      host_data_out <= fn[2] ? ~host_data_out : wd;
      data_disable_out <= dis;
      command_strobe_out <= 1'b1;
      for (int i = 0; i < 8 && !ok; i++) begin
         @(posedge mclk_in);
         if (transfer_done_in === 1'b1) begin
            ok = 1'b1;
            rd = bus_wire_in;
            oe = bus_oe_in;
         end
      end
      command_strobe_out <= 1'b0;
      data_disable_out <= 1'b0;
      host_data_out <= ~host_data_out;
      repeat (2) @(posedge mclk_in);
   endtask
endmodule

/* File: bench/test_host_io_bus_port_interface.sv */
// Self-checking bench for the host bus port.
`timescale 1ns/1ps
module test_host_io_bus_port_interface;
   import host_port_pkg::*;
   // ****************
   // Signals
   // ****************
   localparam logic [6:0] CODE = 7'h2A;
   localparam logic [3:0] PHYS = 4'h5;
   localparam logic [2:0] PID = 3'h6;
   logic mclk_in, arst_n_in, strb, dis, accept, done, oe, run, clr, bready, bevt;
   logic halt, lar_ld, bload, eintr, ok, oe_s;
   logic [0:6] sel;
   logic [0:2] fn;
   logic [0:7] irq;
   logic [0:35] hdata, pout, bus, control_status_reg, bdata_in, bdata_out, rd, w, exp;
   logic [12:0] saddr, faddr;
   logic [11:0] lar_d;
   logic [55:0] fword;
   int tests_run, n_mismatch, cycles;
   assign bus = oe ? pout : hdata;
   host_bus_model host (.mclk_in(mclk_in), .transfer_done_in(done), .bus_oe_in(oe),
      .bus_wire_in(bus), .device_select_lines_out(sel), .function_code_lines_out(fn),
      .command_strobe_out(strb), .data_disable_out(dis), .host_data_out(hdata));
   host_port #(.DEVICE_CODE(CODE), .PHYS_NUMBER(PHYS), .PORT_ID(PID)) uut (
      .mclk_in(mclk_in), .arst_n_in(arst_n_in), .device_select_lines_in(sel),
      .function_code_lines_in(fn), .command_strobe_in(strb), .data_disable_in(dis),
      .command_accept_out(accept), .transfer_done_out(done), .bus_data_lines_in(bus),
      .bus_data_lines_out(pout), .bus_data_lines_oe_out(oe),
      .interrupt_request_lines_out(irq), .engine_run_out(run), .engine_clear_out(clr),
      .engine_start_addr_out(saddr), .control_status_out(control_status_reg), .engine_halt_in(halt),
      .engine_lar_load_in(lar_ld), .engine_next_addr_in(lar_d),
      .engine_fetch_addr_in(faddr), .engine_fetch_word_out(fword),
      .engine_buf_load_in(bload), .engine_intr_in(eintr), .engine_buf_data_in(bdata_in),
      .engine_buf_ready_out(bready), .engine_buf_data_out(bdata_out),
      .engine_data_event_out(bevt));
   initial begin
      mclk_in = 1'b0;
      forever #12.5 mclk_in = ~mclk_in;
   end
   // Generous ceiling; the sequence needs under two hundred cycles
   always @(posedge mclk_in) begin
      cycles++;
      if (cycles == 3000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ****************
   // Helpers
   // ****************
   task automatic chk(input string what, input logic [0:35] e, input logic [0:35] g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic go(input logic [0:6] s, input logic [0:2] f, input logic [0:35] d);
      host.cmd(s, f, d, 1'b0, ok, rd, oe_s);
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // ****************
   // Sequence
   // ****************
   initial begin
      arst_n_in = 1'b0;
      {halt, lar_ld, bload, eintr} = 4'h0;
      lar_d = 12'h5A3;
      faddr = 13'h1ACE;
      bdata_in = 36'h0;
      repeat (5) @(posedge mclk_in);
      arst_n_in <= 1'b1;
      @(posedge mclk_in);
      chk("idle", 12'h000, {accept, done, oe, run, irq});
      lar_ld <= 1'b1;
      @(posedge mclk_in) lar_ld <= 1'b0;
      w = '0;
      w[0] = 1'b1;
      w[1:13] = 13'h1ACE;
      go(CODE, FN_DATA_OUT, w);
      chk("rar", 13'h1ACE, saddr);
      w = '0;
      w[8:35] = 28'hABCDEF1;
      go(CODE, FN_DATA_OUT, w);
      chk("store", 28'hABCDEF1, fword[27:0]);
      go(CODE, FN_DATA_IN, 36'h0);
      chk("store read", 28'hABCDEF1, rd[8:35]);
      w = '1;
      w[CSR_CLEAR_PORT] = 1'b0;
      w[CSR_RUN] = 1'b0;
      exp = w & CSR_WR_MASK;
      exp[CSR_PAR_ERR] = 1'b0;
      exp[CSR_ID_FIRST:CSR_ID_LAST] = PID;
      go(CODE, FN_CONTROL_OUT, w);
      go(CODE, FN_CONTROL_IN, 36'h0);
      chk("csr read", exp & CSR_RD_MASK, rd);
      go(CODE, FN_DATA_OUT, 36'h9_8765_4321);
      chk("buffer", 36'h9_8765_4321, bdata_out);
      chk("rar kept", 13'h1ACE, saddr);
      go(CODE, FN_DATA_IN, 36'h0);
      chk("buffer read", 36'h9_8765_4321, rd);
      host.cmd(CODE, FN_DATA_IN, 36'h0, 1'b1, ok, rd, oe_s);
      chk("disabled drive", 2'h2, {ok, oe_s});
      w = '0;
      w[CSR_SEL_NEXT] = 1'b1;
      go(CODE, FN_CONTROL_OUT, w);
      go(CODE, FN_DATA_IN, 36'h0);
      chk("next addr", {1'b0, 12'h5A3, 23'h0}, rd);
      go(CODE ^ 7'h01, FN_CONTROL_IN, 36'h0);
      chk("foreign", 1'b0, ok);
      go(CODE, FN_INTR_SERVED, 36'h0);
      chk("served", 1'b0, ok);
      w = '0;
      w[CSR_RUN] = 1'b1;
      w[CSR_PIA_FIRST:CSR_PIA_LAST] = 3'h3;
      go(CODE, FN_CONTROL_OUT, w);
      chk("run", 1'b1, run);
      go(CODE, FN_DATA_IN, 36'h0);
      chk("run data in", 1'b0, ok);
      go(CODE, FN_CONTROL_IN, 36'h0);
      chk("run csr", 2'h3, {ok, rd[CSR_RUN]});
      w = '0;
      w[IOP_FN_FIRST:IOP_FN_LAST] = IOP_EXAMINE;
      eintr <= 1'b1;
      bdata_in <= w;
      @(posedge mclk_in) eintr <= 1'b0;
      repeat (2) @(posedge mclk_in);
      chk("irq", 8'h80 >> 3, irq);
      go({PHYS, 3'h3}, FN_INTR_VECTOR, 36'h0);
      chk("vector", w, rd);
      chk("irq off", 8'h00, irq);
      go(CODE, FN_DATA_OUT, 36'h1_2345_6789);
      chk("window", 36'h1_2345_6789, bdata_out);
      chk("window ok", 1'b1, ok);
      go(CODE, FN_DATA_OUT, 36'h0);
      chk("window shut", 1'b0, ok);
      halt <= 1'b1;
      bload <= 1'b1;
      bdata_in <= 36'hC_0FFE_E123;
      @(posedge mclk_in) {halt, bload} <= 2'h0;
      repeat (2) @(posedge mclk_in);
      chk("halt", 1'b0, run);
      chk("engine load", 36'hC_0FFE_E123, bdata_out);
      chk("buffer ready", 1'b1, bready);
      tally_and_finish();
   end
endmodule
